//--- logic/tsi_target.sv
// Two-wire target port of the temperature sensor: bus engine and register-side hand-over
`timescale 1ns/1ps
`include "tsi_map.svh"
module tsi_target #(
	parameter logic [`TSI_TMO_W-1:0] TIMEOUT_CYC =
		`TSI_TMO_W'((`TSI_TMO_MS * 1000000) / `TSI_CLK_SYS_NS)
) (
	input  wire logic        CLK_SYS,
	input  wire logic        NRST,
	input  wire logic        CLK_LINK,
	input  wire logic        SCL_IN,
	input  wire logic        SDA_IN,
	input  wire logic        ADDRESS_STRAP_PIN,
	input  wire logic [15:0] REG_RDATA,
	output logic             SDA_OUT,
	output logic             SDA_OE,
	output logic             HS_MODE,
	output logic [1:0]       POINTER_SEL,
	output logic [7:0]       REG_WDATA,
	output logic             REG_WR_MSB,
	output logic             REG_WR_LSB,
	output logic             REG_RD_STB,
	output logic             GCALL_RST
);
	import tsi_pkg::*;

	// Strap decode: the mismatch flags rule out each connection in turn
	function automatic logic [1:0] strap_dec(input logic [3:0] mis);
		if (!mis[0])
			strap_dec = 2'h0;
		else if (!mis[1])
			strap_dec = 2'h1;
		else if (!mis[2])
			strap_dec = 2'h2;
		else
			strap_dec = 2'h3;
	endfunction : strap_dec

	// Link domain state
	tsi_pins_t   pins_s;            // Filtered pins
	tsi_pins_t   prev_q;            // Pins one link cycle ago
	tsi_state_t  state_q, state_d;  // Engine state
	tsi_state_t  nxt_q, nxt_d;      // State after the acknowledge slot
	logic [3:0]  bit_q, bit_d;      // Bits of the current byte
	logic [7:0]  sh_q, sh_d;        // Byte shift register
	logic        oe_q, oe_d;        // Pull data low
	logic        hs_q, hs_d;        // High-speed filter select
	logic        gc_q, gc_d;        // Transaction is a general call
	logic [1:0]  rxi_q, rxi_d;      // Received byte index in a write
	logic        txi_q, txi_d;      // Next read byte: 0 upper, 1 lower
	logic [3:0]  mis_q, mis_d;      // Strap mismatch flags
	logic        req_q, req_d;      // Event toggle to system side
	tsi_evt_t    evt_q, evt_d;      // Event payload, held until acknowledged
	logic        ack_l;             // Acknowledge toggle seen on link side
	logic        tmo_l;             // Timeout level seen on link side
	logic        rise, fall, start_ev, stop_ev, busy;
	logic [1:0]  strap_bits;
	logic        strap_addr_bit_hi, strap_addr_bit_lo;
	logic        fire;
	tsi_evt_t    fire_evt;
	logic        pins_ok;           // Synchroniser filled, pins trusted
	logic [2:0]  fill_q, fill_d;    // Link cycles since reset, saturating

	// System domain state
	logic        req_s, scl_s;
	logic        ack_q, ack_d;      // Event acknowledge toggle
	logic [15:0] rsp_q, rsp_d;      // Read data snapshot, stable by handshake
	logic [1:0]  ptr_q, ptr_d;      // Pointer selection bits
	logic [7:0]  wdata_q, wdata_d;
	logic        wmsb_q, wmsb_d, wlsb_q, wlsb_d, rd_q, rd_d, gcr_q, gcr_d;
	logic [`TSI_TMO_W-1:0] tcnt_q, tcnt_d;
	logic        tmo_q, tmo_d;      // Clock held low too long
	logic        sda_out_q;         // Open-drain: only ever drives low

	// Pin synchroniser on the link clock
	tsi_sync #(.W(3)) u_pin_sync (
		.clk      (CLK_LINK),
		.rst_n    (NRST),
		.async_in ({ADDRESS_STRAP_PIN, SDA_IN, SCL_IN}),
		.sync_out (pins_s)
	);

	// System-to-link crossing: acknowledge toggle and timeout level
	tsi_sync #(.W(2)) u_l_sync (
		.clk      (CLK_LINK),
		.rst_n    (NRST),
		.async_in ({ack_q, tmo_q}),
		.sync_out ({ack_l, tmo_l})
	);

	// Link-to-system crossing: event toggle and the clock line for timeout
	tsi_sync #(.W(2)) u_s_sync (
		.clk      (CLK_SYS),
		.rst_n    (NRST),
		.async_in ({req_q, SCL_IN}),
		.sync_out ({req_s, scl_s})
	);

	// Bus conditions from the filtered pins
	assign rise     = pins_s.scl & ~prev_q.scl;
	assign fall     = ~pins_s.scl & prev_q.scl;
	assign start_ev = prev_q.sda & ~pins_s.sda & pins_s.scl & prev_q.scl;
	assign stop_ev  = ~prev_q.sda & pins_s.sda & pins_s.scl & prev_q.scl;
	assign busy     = req_q ^ ack_l;
	assign pins_ok  = (fill_q == `TSI_SYNC_FILL);
	assign strap_bits = strap_dec(mis_q);
	assign strap_addr_bit_hi = strap_bits[1];
	assign strap_addr_bit_lo = strap_bits[0];

	// Engine next state; priority is timeout, start, stop, then bit work
	always_comb
	begin
		state_d  = state_q;
		nxt_d    = nxt_q;
		bit_d    = bit_q;
		sh_d     = sh_q;
		oe_d     = oe_q;
		hs_d     = hs_q;
		gc_d     = gc_q;
		rxi_d    = rxi_q;
		txi_d    = txi_q;
		fire     = 1'b0;
		fire_evt = evt_q;
		fill_d   = pins_ok ? fill_q : fill_q + 3'h1;
		// Strap is judged only against the bus; a general call never touches it.
		// Samples taken while the synchroniser fills read zero and would rule
		// out the supply connection for good, so they are skipped.
		mis_d[0] = mis_q[0] | (pins_ok & pins_s.strap);
		mis_d[1] = mis_q[1] | (pins_ok & ~pins_s.strap);
		mis_d[2] = mis_q[2] | (pins_ok & (pins_s.strap ^ pins_s.sda));
		mis_d[3] = mis_q[3] | (pins_ok & (pins_s.strap ^ pins_s.scl));
		if (tmo_l)
		begin
			// Release and wait for a fresh start
			state_d = ST_IDLE;
			oe_d    = 1'b0;
		end
		else if (start_ev)
		begin
			// Start or repeated start restarts framing
			state_d = ST_ADDR;
			bit_d   = 4'h0;
			oe_d    = 1'b0;
		end
		else if (stop_ev)
		begin
			state_d = ST_IDLE;
			oe_d    = 1'b0;
			hs_d    = 1'b0;
		end
		else
		begin
			unique case (state_q)
				ST_IDLE, ST_IGN:
				begin
					// Released until the next start
					oe_d = 1'b0;
				end
				ST_ADDR, ST_RX:
				begin
					if (rise && bit_q != `TSI_BYTE_BITS)
					begin
						// First bit in lands at the top
						sh_d  = {sh_q[6:0], pins_s.sda};
						bit_d = bit_q + 4'h1;
					end
					if (fall && bit_q == `TSI_BYTE_BITS && state_q == ST_ADDR)
					begin
						bit_d = 4'h0;
						if (sh_q[7:1] == {`TSI_ADDR_FIXED, strap_addr_bit_hi,
						                  strap_addr_bit_lo})
						begin
							oe_d    = 1'b1;
							state_d = ST_ACK;
							gc_d    = 1'b0;
							rxi_d   = 2'h0;
							txi_d   = 1'b0;
							nxt_d   = sh_q[0] ? ST_TX : ST_RX;
							if (sh_q[0])
							begin
								fire     = 1'b1;
								fire_evt = '{kind: EV_READ, data: 8'h00};
							end
						end
						else if (sh_q[7:1] == `TSI_GC_ADDR && !sh_q[0])
						begin
							oe_d    = 1'b1;
							state_d = ST_ACK;
							gc_d    = 1'b1;
							rxi_d   = 2'h0;
							nxt_d   = ST_RX;
						end
						else if (sh_q[7:3] == `TSI_HS_CODE)
						begin
							// No acknowledge; switch filters, await restart
							hs_d    = 1'b1;
							state_d = ST_IGN;
						end
						else
						begin
							state_d = ST_IGN;
						end
					end
					else if (fall && bit_q == `TSI_BYTE_BITS)
					begin
						// Pointer, data or general-call command byte
						bit_d   = 4'h0;
						oe_d    = 1'b1;
						state_d = ST_ACK;
						nxt_d   = ST_RX;
						if (rxi_q != `TSI_LAST_RX_IDX)
						begin
							rxi_d = rxi_q + 2'h1;
						end
						if (gc_q)
						begin
							fire     = (rxi_q == 2'h0) && (sh_q == `TSI_GC_RESET_CMD);
							fire_evt = '{kind: EV_GCRST, data: sh_q};
						end
						else if (rxi_q == 2'h0)
						begin
							fire     = 1'b1;
							fire_evt = '{kind: EV_PTR, data: sh_q};
						end
						else
						begin
							// Each byte stands alone, so a lone upper byte is kept
							fire     = (rxi_q != `TSI_LAST_RX_IDX);
							fire_evt = '{kind: (rxi_q == 2'h1) ? EV_WMSB : EV_WLSB,
							             data: sh_q};
						end
					end
				end
				ST_ACK:
				begin
					// Low held across the whole ninth high phase
					if (fall)
					begin
						oe_d    = 1'b0;
						bit_d   = 4'h0;
						state_d = nxt_q;
						if (nxt_q == ST_TX)
						begin
							sh_d = txi_q ? rsp_q[7:0] : rsp_q[15:8];
							oe_d = txi_q ? ~rsp_q[7] : ~rsp_q[15];
						end
					end
				end
				ST_TX:
				begin
					if (rise)
					begin
						bit_d = bit_q + 4'h1;
					end
					if (fall && bit_q == `TSI_BYTE_BITS)
					begin
						oe_d    = 1'b0;
						bit_d   = 4'h0;
						state_d = ST_TACK;
					end
					else if (fall)
					begin
						// Only zeros pull the line; ones are released
						sh_d = {sh_q[6:0], 1'b0};
						oe_d = ~sh_q[6];
					end
				end
				ST_TACK:
				begin
					if (rise)
					begin
						// High in the slot means the controller is done
						state_d = pins_s.sda ? ST_IGN : ST_TACK;
						bit_d   = `TSI_ACK_SEEN;
						txi_d   = ~txi_q;
					end
					else if (fall && bit_q == `TSI_ACK_SEEN)
					begin
						bit_d   = 4'h0;
						state_d = ST_TX;
						sh_d    = txi_q ? rsp_q[7:0] : rsp_q[15:8];
						oe_d    = txi_q ? ~rsp_q[7] : ~rsp_q[15];
					end
				end
				default:
				begin
					state_d = ST_IDLE;
					oe_d    = 1'b0;
				end
			endcase
		end
		// An event is dropped if the previous one is still in flight
		req_d = req_q;
		evt_d = evt_q;
		if (fire && !busy)
		begin
			req_d = ~req_q;
			evt_d = fire_evt;
		end
	end

	// Link domain registers
	always_ff @(posedge CLK_LINK or negedge NRST)
	begin
		if (!NRST)
		begin
			prev_q  <= '{strap: 1'b0, sda: 1'b1, scl: 1'b1};
			state_q <= ST_IDLE;
			nxt_q   <= ST_IDLE;
			bit_q   <= 4'h0;
			sh_q    <= 8'h00;
			oe_q    <= 1'b0;
			hs_q    <= 1'b0;
			gc_q    <= 1'b0;
			rxi_q   <= 2'h0;
			txi_q   <= 1'b0;
			mis_q   <= 4'h0;
			req_q   <= 1'b0;
			evt_q   <= '{kind: EV_PTR, data: 8'h00};
			fill_q  <= 3'h0;
		end
		else
		begin
			prev_q  <= pins_s;
			state_q <= state_d;
			nxt_q   <= nxt_d;
			bit_q   <= bit_d;
			sh_q    <= sh_d;
			oe_q    <= oe_d;
			hs_q    <= hs_d;
			gc_q    <= gc_d;
			rxi_q   <= rxi_d;
			txi_q   <= txi_d;
			mis_q   <= mis_d;
			req_q   <= req_d;
			evt_q   <= evt_d;
			fill_q  <= fill_d;
		end
	end

	// System side: take events, keep the pointer, count clock-low time
	always_comb
	begin
		ack_d   = ack_q;
		rsp_d   = rsp_q;
		ptr_d   = ptr_q;
		wdata_d = wdata_q;
		wmsb_d  = 1'b0;
		wlsb_d  = 1'b0;
		rd_d    = 1'b0;
		gcr_d   = 1'b0;
		if (req_s != ack_q)
		begin
			ack_d = req_s;
			unique case (evt_q.kind)
				EV_PTR:   ptr_d = evt_q.data[1:0];
				EV_WMSB:
				begin
					wdata_d = evt_q.data;
					wmsb_d  = 1'b1;
				end
				EV_WLSB:
				begin
					wdata_d = evt_q.data;
					wlsb_d  = 1'b1;
				end
				EV_READ:
				begin
					rsp_d = REG_RDATA;
					rd_d  = 1'b1;
				end
				EV_GCRST:
				begin
					ptr_d = `TSI_PTR_RESET;
					gcr_d = 1'b1;
				end
				default:  ack_d = req_s;
			endcase
		end
		// Saturating counter; the level is released once the clock goes high
		tcnt_d = scl_s ? '0 : ((tcnt_q == TIMEOUT_CYC) ? tcnt_q : tcnt_q + 1'b1);
		tmo_d  = !scl_s && (tcnt_q == TIMEOUT_CYC);
	end

	// System domain registers
	always_ff @(posedge CLK_SYS or negedge NRST)
	begin
		if (!NRST)
		begin
			ack_q     <= 1'b0;
			rsp_q     <= 16'h0000;
			ptr_q     <= `TSI_PTR_RESET;
			wdata_q   <= 8'h00;
			wmsb_q    <= 1'b0;
			wlsb_q    <= 1'b0;
			rd_q      <= 1'b0;
			gcr_q     <= 1'b0;
			tcnt_q    <= '0;
			tmo_q     <= 1'b0;
			sda_out_q <= 1'b0;
		end
		else
		begin
			ack_q     <= ack_d;
			rsp_q     <= rsp_d;
			ptr_q     <= ptr_d;
			wdata_q   <= wdata_d;
			wmsb_q    <= wmsb_d;
			wlsb_q    <= wlsb_d;
			rd_q      <= rd_d;
			gcr_q     <= gcr_d;
			tcnt_q    <= tcnt_d;
			tmo_q     <= tmo_d;
			sda_out_q <= 1'b0;
		end
	end

	// No clock output exists: the port never drives the clock line
	assign SDA_OUT     = sda_out_q;
	assign SDA_OE      = oe_q;
	assign HS_MODE     = hs_q;
	assign POINTER_SEL = ptr_q;
	assign REG_WDATA   = wdata_q;
	assign REG_WR_MSB  = wmsb_q;
	assign REG_WR_LSB  = wlsb_q;
	assign REG_RD_STB  = rd_q;
	assign GCALL_RST   = gcr_q;

	// Checks on the link clock
	sequence s_addr_end;
		fall && !tmo_l && !start_ev && !stop_ev && state_q == ST_ADDR
			&& bit_q == `TSI_BYTE_BITS;
	endsequence
	property p_start_frame;
		@(posedge CLK_LINK) disable iff (!NRST)
		(start_ev && !tmo_l) |=> (state_q == ST_ADDR && bit_q == 4'h0 && !oe_q);
	endproperty
	a_start_frame: assert property (p_start_frame) else $error("start not framed");
	property p_stop_idle;
		@(posedge CLK_LINK) disable iff (!NRST)
		(stop_ev && !tmo_l && !start_ev) |=> (state_q == ST_IDLE && !oe_q);
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("stop not idled");
	property p_idle_free;
		@(posedge CLK_LINK) disable iff (!NRST)
		(state_q == ST_IDLE || state_q == ST_IGN) |-> !oe_q;
	endproperty
	a_idle_free: assert property (p_idle_free) else $error("line pulled idle");
	property p_ack_held;
		@(posedge CLK_LINK) disable iff (!NRST)
		(state_q == ST_ACK && !fall && !start_ev && !stop_ev && !tmo_l) |=> oe_q;
	endproperty
	a_ack_held: assert property (p_ack_held) else $error("ack dropped early");
	property p_own_ack;
		@(posedge CLK_LINK) disable iff (!NRST)
		(s_addr_end and (sh_q[7:1] == {`TSI_ADDR_FIXED, strap_bits}))
			|=> (oe_q && state_q == ST_ACK);
	endproperty
	a_own_ack: assert property (p_own_ack) else $error("own address not acked");
	property p_hs_noack;
		@(posedge CLK_LINK) disable iff (!NRST)
		(s_addr_end and (sh_q[7:3] == `TSI_HS_CODE)) |=> (!oe_q && hs_q) [*2];
	endproperty
	a_hs_noack: assert property (p_hs_noack) else $error("hs code mishandled");
	property p_hs_exit;
		@(posedge CLK_LINK) disable iff (!NRST)
		(stop_ev && !tmo_l && !start_ev) |=> !hs_q;
	endproperty
	a_hs_exit: assert property (p_hs_exit) else $error("hs kept after stop");
	property p_timeout;
		@(posedge CLK_LINK) disable iff (!NRST)
		tmo_l |=> (state_q == ST_IDLE && !oe_q);
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout not honoured");

	// Checks on the system clock
	property p_gc_ptr;
		@(posedge CLK_SYS) disable iff (!NRST)
		gcr_q |-> (ptr_q == `TSI_PTR_RESET);
	endproperty
	a_gc_ptr: assert property (p_gc_ptr) else $error("pointer kept after reset");
	property p_ptr_hold;
		@(posedge CLK_SYS) disable iff (!NRST)
		!(req_s != ack_q && (evt_q.kind == EV_PTR || evt_q.kind == EV_GCRST))
			|=> $stable(ptr_q);
	endproperty
	a_ptr_hold: assert property (p_ptr_hold) else $error("pointer drifted");

endmodule : tsi_target

//--- logic/tsi_map.svh
// Constants of the temperature sensor two-wire target port
`ifndef TSI_MAP_SVH
`define TSI_MAP_SVH

`define TSI_ADDR_FIXED   5'h12
`define TSI_GC_ADDR      7'h00
`define TSI_GC_RESET_CMD 8'h06
`define TSI_HS_CODE      5'h01
`define TSI_PTR_RESET    2'h0
`define TSI_BYTE_BITS    4'h8
`define TSI_ACK_SEEN     4'h1
`define TSI_LAST_RX_IDX  2'h3
`define TSI_TMO_MS       30
`define TSI_CLK_SYS_NS   100
`define TSI_TMO_W        19
`define TSI_SYNC_FILL    3'h4

`endif

//--- logic/tsi_pkg.sv
// Types shared by the two-wire target port
package tsi_pkg;

	// Protocol engine states on the link clock
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_RX   = 3'h2,
		ST_ACK  = 3'h3,
		ST_TX   = 3'h4,
		ST_TACK = 3'h5,
		ST_IGN  = 3'h6
	} tsi_state_t;

	// Events handed from the link side to the system side
	typedef enum logic [2:0] {
		EV_PTR   = 3'h0,
		EV_WMSB  = 3'h1,
		EV_WLSB  = 3'h2,
		EV_READ  = 3'h3,
		EV_GCRST = 3'h4
	} tsi_evt_kind_t;

	typedef struct packed {
		tsi_evt_kind_t kind;
		logic [7:0]    data;
	} tsi_evt_t;

	// Sampled bus pins, kept together so they see the same delay
	typedef struct packed {
		logic strap;
		logic sda;
		logic scl;
	} tsi_pins_t;

endpackage : tsi_pkg

//--- logic/tsi_sync.sv
// Three-stage synchroniser with agreement filter, one lane per bit
`timescale 1ns/1ps
module tsi_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] s1_q;     // Metastability catch, read only by s2
	logic [W-1:0] s2_q;     // Second stage
	logic [W-1:0] s3_q;     // Third stage
	logic [W-1:0] out_q;    // Filtered value
	logic [W-1:0] out_d;

	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_lane
			// A change counts only once stages two and three agree
			always_comb
			begin
				out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
			end
		end
	endgenerate

	// Register stages; reset to zero, not to the pin level, so the output
	// cannot be trusted until the stages have filled
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_q  <= '0;
			s2_q  <= '0;
			s3_q  <= '0;
			out_q <= '0;
		end
		else
		begin
			s1_q  <= async_in;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			out_q <= out_d;
		end
	end

	assign sync_out = out_q;

endmodule : tsi_sync

//--- tb/tsi_ctrl_model.sv
// Behavioural two-wire bus controller facing the target port
`timescale 1ns/1ps
module tsi_ctrl_model (
	output logic      scl,
	output logic      sda_o,
	input  wire logic sda
);
	// Quarter bit time: 4 us per bit, 250 kHz, inside the fast-mode range
	localparam int Q = 1000;

	// Both lines released at power-up, so the bus starts idle
	initial
	begin
		scl   = 1'b1;
		sda_o = 1'b1;
	end

	// Start or repeated start: data falls while the clock is high
	task automatic start();
		sda_o = 1'b1;
		#Q scl = 1'b1;
		#Q sda_o = 1'b0;
		#Q scl = 1'b0;
	endtask : start

	// Stop: data rises while the clock is high
	task automatic stop();
		#Q sda_o = 1'b0;
		#Q scl = 1'b1;
		#Q sda_o = 1'b1;
		#Q;
	endtask : stop

	// One clock pulse; data moves only while the clock is low
	task automatic pulse(input logic b, output logic s0, output logic s1);
		#Q sda_o = b;
		#Q scl = 1'b1;
		#10 s0 = sda;
		#(2*Q-20) s1 = sda;
		#10 scl = 1'b0;
	endtask : pulse

	// Byte out; stall parks the clock low before the ack pulse, long enough to time out
	task automatic wr_byte(input logic [7:0] d, input logic stall, output logic ack);
		logic s0, s1;
		for (int i = 7; i >= 0; i--)
			pulse(d[i], s0, s1);
		if (stall)
			#25000;
		pulse(1'b1, s0, s1);
		// Ack counts only if low at both ends of the high phase
		ack = !s0 && !s1;
	endtask : wr_byte

	// Byte in, then our own ack or a released line to end the read
	task automatic rd_byte(input logic nak, output logic [7:0] d);
		logic s0;
		for (int i = 7; i >= 0; i--)
			pulse(1'b1, s0, d[i]);
		pulse(nak, s0, s0);
	endtask : rd_byte
endmodule : tsi_ctrl_model

//--- tb/tb.sv
// Self-checking bench of the two-wire target port
`timescale 1ns/1ps
module tb;
	localparam logic [7:0] ADW = 8'h96; // Own address, strap on clock, write
	localparam logic [7:0] ADR = 8'h97; // Same, read
	logic        clk_sys  = 1'b0; // 100 ns system clock
	logic        clk_link = 1'b0; // 48 ns link clock
	logic        nrst     = 1'b0;
	logic        scl, ctl_sda, strap, sda_out, sda_oe, hs_mode;
	logic        wr_msb, wr_lsb, rd_stb, gc_rst;
	logic [1:0]  strap_sel = 2'h3;   // 0 ground, 1 supply, 2 data, 3 clock
	logic [15:0] rdata     = 16'hC35A;
	logic [1:0]  ptr_sel;
	logic [7:0]  wdata, last_msb, last_lsb;
	logic        sda_w;
	int          error_cnt, total_checks, n_msb, n_lsb, n_rd, n_gc;

	always #50 clk_sys = ~clk_sys;
	always #24 clk_link = ~clk_link;
	// Wired-AND with pull-up: the device only ever pulls low
	assign sda_w = ctl_sda & ~sda_oe;
	assign strap = strap_sel[1] ? (strap_sel[0] ? scl : sda_w) : strap_sel[0];

	tsi_ctrl_model ctl_u (.scl(scl), .sda_o(ctl_sda), .sda(sda_w));
	tsi_target #(.TIMEOUT_CYC(19'h000C8)) dut_u (
		.CLK_SYS(clk_sys), .CLK_LINK(clk_link), .NRST(nrst), .SCL_IN(scl),
		.SDA_IN(sda_w), .ADDRESS_STRAP_PIN(strap), .REG_RDATA(rdata),
		.SDA_OUT(sda_out), .SDA_OE(sda_oe), .HS_MODE(hs_mode),
		.POINTER_SEL(ptr_sel), .REG_WDATA(wdata), .REG_WR_MSB(wr_msb),
		.REG_WR_LSB(wr_lsb), .REG_RD_STB(rd_stb), .GCALL_RST(gc_rst));

	// Count strobes; one-cycle pulses are caught on the edge they stand
	always @(posedge clk_sys)
	begin
		n_msb    <= n_msb + int'(wr_msb === 1'b1);
		n_lsb    <= n_lsb + int'(wr_lsb === 1'b1);
		n_rd     <= n_rd + int'(rd_stb === 1'b1);
		n_gc     <= n_gc + int'(gc_rst === 1'b1);
		last_msb <= (wr_msb === 1'b1) ? wdata : last_msb;
		last_lsb <= (wr_lsb === 1'b1) ? wdata : last_lsb;
	end

	// Whenever the device drives, it may only pull low
	always @(posedge clk_link)
		if (sda_oe === 1'b1)
			chk("sda_out", 16'h0000, 16'(sda_out));

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic test_done();
		if (error_cnt == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done

	task automatic wt();
		repeat (20) @(posedge clk_sys);
	endtask : wt

	// Byte to the device and its expected acknowledge
	task automatic wb(input logic [7:0] d, input logic exp);
		logic a;
		ctl_u.wr_byte(d, 1'b0, a);
		chk("ack", 16'(exp), 16'(a));
	endtask : wb

	// Byte from the device and its expected value
	task automatic rb(input logic nak, input logic [7:0] exp);
		logic [7:0] d;
		ctl_u.rd_byte(nak, d);
		chk("rd byte", 16'(exp), 16'(d));
	endtask : rb

	task automatic do_reset();
		@(posedge clk_sys) nrst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (10) @(posedge clk_sys);
	endtask : do_reset

	task automatic t_reset();
		do_reset();
		chk("ptr", 16'h0000, 16'(ptr_sel));
		chk("oe", 16'h0000, 16'(sda_oe));
		chk("hs", 16'h0000, 16'(hs_mode));
	endtask : t_reset

	// Each strap connection: own address acked, neighbour ignored
	task automatic t_strap();
		for (int s = 0; s < 4; s++)
		begin
			@(posedge clk_sys) strap_sel <= 2'(s);
			do_reset();
			chk("ptr", 16'h0000, 16'(ptr_sel));
			ctl_u.start();
			wb({5'h12, 2'(s), 1'b0}, 1'b1);
			wb({6'h00, 2'(s)}, 1'b1);
			ctl_u.stop();
			wt();
			chk("ptr", 16'(s), 16'(ptr_sel));
			ctl_u.start();
			wb({5'h12, 2'(s ^ 1), 1'b0}, 1'b0);
			wb(8'h00, 1'b0);
			ctl_u.stop();
		end
	endtask : t_strap

	// Lone upper byte, then a full pair plus a surplus byte
	task automatic t_write();
		ctl_u.start();
		wb(ADW, 1'b1);
		wb(8'h01, 1'b1);
		wb(8'hA5, 1'b1);
		ctl_u.stop();
		wt();
		chk("msb cnt", 16'h0001, 16'(n_msb));
		chk("lsb cnt", 16'h0000, 16'(n_lsb));
		chk("msb", 16'h00A5, 16'(last_msb));
		ctl_u.start();
		wb(ADW, 1'b1);
		wb(8'h01, 1'b1);
		wb(8'h3C, 1'b1);
		wb(8'hC3, 1'b1);
		wb(8'h77, 1'b1);
		ctl_u.stop();
		wt();
		chk("msb cnt", 16'h0002, 16'(n_msb));
		chk("lsb cnt", 16'h0001, 16'(n_lsb));
		chk("msb", 16'h003C, 16'(last_msb));
		chk("lsb", 16'h00C3, 16'(last_lsb));
	endtask : t_write

	// Two-byte read, then a one-byte read with no new pointer
	task automatic t_read();
		ctl_u.start();
		wb(ADW, 1'b1);
		wb(8'h01, 1'b1);
		ctl_u.start();
		wb(ADR, 1'b1);
		rb(1'b0, 8'hC3);
		rb(1'b1, 8'h5A);
		ctl_u.stop();
		wt();
		chk("rd cnt", 16'h0001, 16'(n_rd));
		ctl_u.start();
		wb(ADR, 1'b1);
		rb(1'b1, 8'hC3);
		ctl_u.stop();
		wt();
		chk("rd cnt", 16'h0002, 16'(n_rd));
		chk("ptr", 16'h0001, 16'(ptr_sel));
		chk("oe", 16'h0000, 16'(sda_oe));
	endtask : t_read

	// Reset command pulses once, another command does not, address kept
	task automatic t_gcall();
		ctl_u.start();
		wb(8'h00, 1'b1);
		wb(8'h06, 1'b1);
		ctl_u.stop();
		wt();
		chk("ptr", 16'h0000, 16'(ptr_sel));
		ctl_u.start();
		wb(8'h00, 1'b1);
		wb(8'h04, 1'b1);
		ctl_u.stop();
		wt();
		chk("gc cnt", 16'h0001, 16'(n_gc));
		ctl_u.start();
		wb(ADW, 1'b1);
		wb(8'h01, 1'b1);
		ctl_u.stop();
	endtask : t_gcall

	// High-speed code unacked and mode set, repeated start answered, mode dropped at stop
	task automatic t_hs();
		ctl_u.start();
		wb(8'h0B, 1'b0);
		wt();
		chk("hs", 16'h0001, 16'(hs_mode));
		ctl_u.start();
		wb(ADW, 1'b1);
		wb(8'h01, 1'b1);
		ctl_u.stop();
		wt();
		chk("hs", 16'h0000, 16'(hs_mode));
	endtask : t_hs

	// Clock held low in the ack slot: line released, next start answered
	task automatic t_tmo();
		logic a;
		ctl_u.start();
		ctl_u.wr_byte(ADW, 1'b1, a);
		chk("tmo ack", 16'h0000, 16'(a));
		ctl_u.stop();
		ctl_u.start();
		wb(ADW, 1'b1);
		wb(8'h01, 1'b1);
		ctl_u.stop();
	endtask : t_tmo

	initial
	begin
		t_reset();
		t_strap();
		t_write();
		t_read();
		t_gcall();
		t_hs();
		t_tmo();
		test_done();
	end

	// Watchdog: the sequence needs about 1.7 ms
	initial
	begin
		#4000000;
		error_cnt++;
		test_done();
	end
endmodule : tb
